// ===== bsc_params.svh
/*
 Constants for the boot swap chip select decoder: address windows,
 page register layout, register addresses, bus cycle widths.
 Assumes inclusion by bare name from the package and modules.
*/
`ifndef BSC_PARAMS_SVH
`define BSC_PARAMS_SVH

`define BSC_ADDR_W 20
`define BSC_BOOT0_LO 20'h0_0000
`define BSC_BOOT0_HI 20'h0_1FFF
`define BSC_BOOT1_LO 20'h0_2000
`define BSC_BOOT1_HI 20'h0_3FFF
`define BSC_MAIN_LO 20'h1_0000
`define BSC_MAIN_HI 20'h1_FFFF
`define BSC_EXEC_LO 20'h0_0000
`define BSC_EXEC_HI 20'h0_3FFF
`define BSC_PAGE_RESET 8'h00
`define BSC_SWAP_BIT 6
`define BSC_ADDR_PAGE 4'h0
`define BSC_ADDR_CTRL 4'h1
`define BSC_ADDR_STAT 4'h2
`define BSC_ADDR_LAST 4'h3
`define BSC_CTRL_PROG 0
`define BSC_CTRL_SWAP 1
`define BSC_BUS_DEF_W 8'h10
`define BSC_BUS_REG_W 8'h08

`endif

// ===== bsc_pkg.sv
/*
 Types shared by both ends of the boot swap decoder link.
 Assumes bsc_params.svh is on the include path.
*/
`include "bsc_params.svh"

package bsc_pkg;
    typedef logic [`BSC_ADDR_W-1:0] bsc_addr_t;
    typedef logic [7:0] bsc_byte_t;
    typedef enum logic [1:0] {
        BSC_ST_IDLE,
        BSC_ST_WRITE,
        BSC_ST_READ
    } bsc_host_st_t;
endpackage

// ===== bsc_link_if.sv
/*
 Link between the decoder device and the microcontroller side.
 Assumes both ends share i_core_clk; no clocking block.
*/
`timescale 1ns/1ps

interface bsc_link_if;
    import bsc_pkg::*;
    bsc_addr_t addr;       // Fetch / access address from host
    bsc_byte_t wdata;      // Page register write data
    logic wr;              // Page register write strobe
    logic rd;              // Page register read strobe
    bsc_byte_t rdata;      // Page register read data
    logic bus_en;          // Device connected to the bus
    logic mcu_rst;         // Reset held on the host during programming
    logic [7:0] bus_width; // Host bus cycle width in bits

    modport device (
        input addr, wdata, wr, rd, bus_width,
        output rdata, bus_en, mcu_rst
    );
    modport host (
        output addr, wdata, wr, rd, bus_width,
        input rdata, bus_en, mcu_rst
    );
endinterface

// ===== bsc_device.sv
/*
 Boot swap chip select decoder, device end.
 Holds the page register and drives the three chip selects.
 Assumes addresses and strobes synchronous to i_core_clk.
*/
`timescale 1ns/1ps
`include "bsc_params.svh"

module bsc_device (
    input wire logic i_core_clk,          // Core clock
    input wire logic i_rst,               // Async reset, high
    bsc_link_if.device link,              // Host link
    input wire logic i_prog_req,          // Test port programming active
    input wire logic [1:0] i_prog_area,   // Area being programmed
    output logic o_boot_sector0_select,   // Boot sector 0 select
    output logic o_boot_sector1_select,   // Boot sector 1 select
    output logic o_main_sector0_select,   // Main sector 0 select
    output logic o_prog_active,           // Programming in progress
    output logic [3:0] o_prog_area_mask   // Areas touched by programming
);
    import bsc_pkg::*;

    typedef struct packed {
        bsc_byte_t page_r;
        bsc_byte_t rdata_r;
        logic prog_en_r;
        logic prog_r;
        logic [3:0] area_mask_r;
        logic b0_r;
        logic b1_r;
        logic m0_r;
        logic bus_en_r;
        logic mcu_rst_r;
    } bsc_dev_state_t;

    bsc_dev_state_t s_r;
    bsc_dev_state_t s_nxt;
    logic swap;
    logic sel_b0;
    logic sel_b1;
    logic sel_m0;

    ////////////////////////////////////////////////////////////////////////
    // Decode: the bit after a write is already in page_r, so next fetch moves
    always_comb begin
        swap = s_r.page_r[`BSC_SWAP_BIT];
        sel_b0 = !swap && link.addr >= `BSC_BOOT0_LO && link.addr <= `BSC_BOOT0_HI;
        sel_b1 = !swap && link.addr >= `BSC_BOOT1_LO && link.addr <= `BSC_BOOT1_HI;
        sel_m0 = (!swap && link.addr >= `BSC_MAIN_LO && link.addr <= `BSC_MAIN_HI)
            || (swap && link.addr >= `BSC_EXEC_LO && link.addr <= `BSC_EXEC_HI);
    end

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        s_nxt = s_r;
        s_nxt.prog_r = s_r.prog_en_r && i_prog_req;
        if (s_nxt.prog_r) begin
            s_nxt.area_mask_r[i_prog_area] = 1'b1;
        end
        s_nxt.bus_en_r = !s_nxt.prog_r;
        s_nxt.mcu_rst_r = s_nxt.prog_r;
        // Strobes ignored while disconnected
        if (link.wr && !s_r.prog_r) begin
            s_nxt.page_r = link.wdata;
        end
        s_nxt.rdata_r = (link.rd && !s_r.prog_r) ? s_r.page_r : `BSC_PAGE_RESET;
        // Selects registered for clean outputs; masked while disconnected
        s_nxt.b0_r = sel_b0 && !s_r.prog_r;
        s_nxt.b1_r = sel_b1 && !s_r.prog_r;
        s_nxt.m0_r = sel_m0 && !s_r.prog_r;
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            s_r <= '0;
            s_r.page_r <= `BSC_PAGE_RESET;
            s_r.prog_en_r <= 1'b1;
            s_r.bus_en_r <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registered copies add one cycle; link rdata, bus_en and mcu_rst are registered too
    assign o_boot_sector0_select = s_r.b0_r;
    assign o_boot_sector1_select = s_r.b1_r;
    assign o_main_sector0_select = s_r.m0_r;
    assign o_prog_active = s_r.prog_r;
    assign o_prog_area_mask = s_r.area_mask_r;
    assign link.rdata = s_r.rdata_r;
    assign link.bus_en = s_r.bus_en_r;
    assign link.mcu_rst = s_r.mcu_rst_r;
endmodule

// ===== bsc_host.sv
/*
 Microcontroller side of the boot swap link.
 Register port: PAGE mirror, CTRL (program, swap request), STAT.
 Assumes device on bsc_link_if and same clock.
*/
// Chosen here: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`include "bsc_params.svh"

module bsc_host (
    input wire logic i_core_clk,        // Core clock
    input wire logic i_rst,             // Async reset, high
    bsc_link_if.host link,              // Device link
    input wire logic [3:0] i_reg_addr,  // Register address
    input wire logic [7:0] i_reg_wdata, // Register write data
    input wire logic i_reg_wr,          // Write strobe
    input wire logic i_reg_rd,          // Read strobe
    output logic [7:0] o_reg_rdata,     // Read data, cycle after strobe
    input wire logic i_switch,          // Board swap switch
    input wire logic [`BSC_ADDR_W-1:0] i_fetch_addr, // Fetch address
    output logic o_busy                 // Access in flight
);
    import bsc_pkg::*;

    typedef struct packed {
        bsc_host_st_t st;
        bsc_addr_t addr;
        bsc_byte_t wdata;
        logic wr;
        logic rd;
        bsc_byte_t page;
        bsc_byte_t rdata;
        logic busy;
    } bsc_host_state_t;

    bsc_host_state_t s_r;
    bsc_host_state_t s_nxt;

    always_comb begin
        s_nxt = s_r;
        s_nxt.wr = 1'b0;
        s_nxt.rd = 1'b0;
        s_nxt.addr = i_fetch_addr;
        s_nxt.rdata = 8'h00;
        case (s_r.st)
            BSC_ST_IDLE: begin
                // Held in reset by the device: no accesses
                if (link.bus_en && !link.mcu_rst && i_reg_wr
                    && i_reg_addr == `BSC_ADDR_CTRL) begin
                    if (i_reg_wdata[`BSC_CTRL_SWAP]) begin
                        s_nxt.wdata = 8'h00;
                        s_nxt.wdata[`BSC_SWAP_BIT] = i_switch;
                        s_nxt.wr = 1'b1;
                        s_nxt.st = BSC_ST_WRITE;
                    end else if (i_reg_wdata[`BSC_CTRL_PROG]) begin
                        s_nxt.rd = 1'b1;
                        s_nxt.st = BSC_ST_READ;
                    end
                end
            end
            BSC_ST_WRITE: begin
                s_nxt.page = s_r.wdata;
                s_nxt.st = BSC_ST_IDLE;
            end
            BSC_ST_READ: begin
                // Device answers the cycle after the strobe, so wait one edge
                if (!s_r.rd) begin
                    s_nxt.page = link.rdata;
                    s_nxt.st = BSC_ST_IDLE;
                end
            end
            default: s_nxt.st = BSC_ST_IDLE;
        endcase
        s_nxt.busy = s_nxt.st != BSC_ST_IDLE;
        if (i_reg_rd) begin
            case (i_reg_addr)
                `BSC_ADDR_PAGE: s_nxt.rdata = s_r.page;
                `BSC_ADDR_STAT: s_nxt.rdata = {5'h00, link.mcu_rst, link.bus_en, s_r.busy};
                default: s_nxt.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            s_r <= '0;
            s_r.st <= BSC_ST_IDLE;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Fetch stream runs on unchanged across the swap; images must match there
    assign link.addr = s_r.addr;
    assign link.wdata = s_r.wdata;
    assign link.wr = s_r.wr;
    assign link.rd = s_r.rd;
    // Memory cycles 16 bit, register cycles 8 bit
    assign link.bus_width = (s_r.wr || s_r.rd) ? `BSC_BUS_REG_W : `BSC_BUS_DEF_W;
    assign o_reg_rdata = s_r.rdata;
    assign o_busy = s_r.busy;
endmodule

// ===== bsc_link_monitor.sv
/*
 Concurrent checks on the decoder link and the device selects.
 Assumes the testbench feeds the interface signals by name.
*/
`timescale 1ns/1ps
module bsc_link_monitor (
    input wire logic i_core_clk, // Clock
    input wire logic i_rst, // Async reset, high
    input wire bsc_pkg::bsc_addr_t addr, // Link address
    input wire bsc_pkg::bsc_byte_t wdata, // Page write data
    input wire logic wr, // Page write strobe
    input wire logic rd, // Page read strobe
    input wire bsc_pkg::bsc_byte_t rdata, // Page read data
    input wire logic bus_en, // Device on the bus
    input wire logic mcu_rst, // Host held
    input wire logic [7:0] bus_width, // Host cycle width
    input wire logic i_prog_req, // Programming request
    input wire logic o_boot_sector0_select, // Boot sector 0
    input wire logic o_boot_sector1_select, // Boot sector 1
    input wire logic o_main_sector0_select, // Main sector 0
    input wire logic o_prog_active // Programming active
);
    import bsc_pkg::*;
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_rst);
    // Shadow of the page register, so decode is judged on the stored bit
    bsc_byte_t page_r;
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) page_r <= 8'h00;
        else if (wr && bus_en) page_r <= wdata;
    end
    ////////////////////////////////////////////////////////////
    boot0_decode_a: assert property (
        !$past(i_rst) && $past(bus_en) && bus_en |-> o_boot_sector0_select ==
        (!$past(page_r[6]) && $past(addr) <= 20'h0_1FFF)) else $error("boot0 decode");
    boot1_decode_a: assert property (
        !$past(i_rst) && $past(bus_en) && bus_en |-> o_boot_sector1_select ==
        (!$past(page_r[6]) && $past(addr) >= 20'h0_2000 && $past(addr) <= 20'h0_3FFF))
        else $error("boot1 decode");
    main_decode_a: assert property (
        !$past(i_rst) && $past(bus_en) && bus_en |-> o_main_sector0_select ==
        ($past(page_r[6]) ? $past(addr) <= 20'h0_3FFF :
        ($past(addr) >= 20'h1_0000 && $past(addr) <= 20'h1_FFFF))) else $error("main decode");
    page_read_a: assert property (
        $past(rd) && $past(bus_en) |-> rdata == $past(page_r)) else $error("page read");
    prog_isolate_a: assert property (
        i_prog_req |=> !bus_en && mcu_rst && o_prog_active) else $error("prog entry");
    prog_release_a: assert property (
        !i_prog_req |=> bus_en && !mcu_rst && !o_prog_active) else $error("prog exit");
    prog_quiet_a: assert property (
        $past(o_prog_active) |-> !(o_boot_sector0_select || o_boot_sector1_select ||
        o_main_sector0_select)) else $error("select while programming");
    cycle_width_a: assert property (
        bus_width == ((wr || rd) ? 8'h08 : 8'h10)) else $error("cycle width");
    cover property ($past(page_r[6]) && o_main_sector0_select);
    cover property (o_prog_active);
    cover property (rd ##1 rdata != 8'h00);
endmodule

// ===== testbench.sv
/*
 Self-checking bench joining host and device over bsc_link_if.
 Assumes the design files and bsc_params.svh are compiled first.
*/
`timescale 1ns/1ps
module testbench;
    import bsc_pkg::*;
    logic i_core_clk, i_rst, i_prog_req, i_reg_wr, i_reg_rd, i_switch;
    logic [1:0] i_prog_area;
    logic [3:0] i_reg_addr, mask;
    logic [7:0] i_reg_wdata, rdata;
    bsc_addr_t i_fetch_addr;
    logic b0, b1, m0, pact, busy;
    int err_count = 0, total_checks = 0, cyc = 0;
    typedef struct { logic sw; bsc_addr_t a; logic [2:0] sel; } bsc_row_t;
    // Selects are {boot0, boot1, main}; edges of each window on both sides, except just below main
    bsc_row_t rows[12] = '{'{0, 20'h0_0000, 3'h4}, '{0, 20'h0_1FFF, 3'h4},
        '{0, 20'h0_2000, 3'h2}, '{0, 20'h0_3FFF, 3'h2}, '{0, 20'h0_4000, 3'h0},
        '{0, 20'h1_0000, 3'h1}, '{0, 20'h1_FFFF, 3'h1}, '{0, 20'h2_0000, 3'h0},
        '{1, 20'h0_0000, 3'h1}, '{1, 20'h0_3FFF, 3'h1}, '{1, 20'h0_4000, 3'h0},
        '{1, 20'h1_0000, 3'h0}};
    bsc_link_if bsc_link_if_i ();
    bsc_device bsc_device_i (.i_core_clk(i_core_clk), .i_rst(i_rst), .link(bsc_link_if_i),
        .i_prog_req(i_prog_req), .i_prog_area(i_prog_area), .o_boot_sector0_select(b0),
        .o_boot_sector1_select(b1), .o_main_sector0_select(m0), .o_prog_active(pact),
        .o_prog_area_mask(mask));
    bsc_host bsc_host_i (.i_core_clk(i_core_clk), .i_rst(i_rst), .link(bsc_link_if_i),
        .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr),
        .i_reg_rd(i_reg_rd), .o_reg_rdata(rdata), .i_switch(i_switch),
        .i_fetch_addr(i_fetch_addr), .o_busy(busy));
    bsc_link_monitor bsc_link_monitor_i (.i_core_clk(i_core_clk), .i_rst(i_rst),
        .addr(bsc_link_if_i.addr), .wdata(bsc_link_if_i.wdata), .wr(bsc_link_if_i.wr),
        .rd(bsc_link_if_i.rd), .rdata(bsc_link_if_i.rdata), .bus_en(bsc_link_if_i.bus_en),
        .mcu_rst(bsc_link_if_i.mcu_rst), .bus_width(bsc_link_if_i.bus_width),
        .i_prog_req(i_prog_req), .o_boot_sector0_select(b0), .o_boot_sector1_select(b1),
        .o_main_sector0_select(m0), .o_prog_active(pact));
    ////////////////////////////////////////////////////////////
    task chk(string n, logic [7:0] s, logic [7:0] e);
        total_checks++;
        if (s !== e) begin
            err_count++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    task results();
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task wr_reg(logic [3:0] a, logic [7:0] d);
        @(posedge i_core_clk) {i_reg_addr, i_reg_wdata, i_reg_wr} <= {a, d, 1'b1};
        @(posedge i_core_clk) i_reg_wr <= 1'b0;
    endtask
    task rd_chk(string n, logic [3:0] a, logic [7:0] e);
        @(posedge i_core_clk) {i_reg_addr, i_reg_rd} <= {a, 1'b1};
        @(posedge i_core_clk) i_reg_rd <= 1'b0;
        #1 chk(n, rdata, e);
    endtask
    initial begin
        i_core_clk = 0;
        forever #12.5 i_core_clk = ~i_core_clk;
    end
    // Hang guard, far above the 110 or so cycles the run needs
    always @(posedge i_core_clk) begin
        cyc++;
        if (cyc == 3000) begin
            err_count++;
            results();
        end
    end
    initial begin
        {i_rst, i_prog_req, i_reg_wr, i_reg_rd, i_switch, i_prog_area} = 7'h40;
        {i_reg_addr, i_reg_wdata, i_fetch_addr} = 32'h0000_0000;
        repeat (20) @(posedge i_core_clk);
        i_rst <= 1'b0;
        rd_chk("page", 4'h0, 8'h00);
        rd_chk("status", 4'h2, 8'h02);
        rd_chk("unmapped", 4'h3, 8'h00);
        for (int i = 0; i < 12; i++) begin
            if (rows[i].sw !== i_switch) begin
                @(posedge i_core_clk) i_switch <= rows[i].sw;
                wr_reg(4'h1, 8'h02);
                repeat (4) @(posedge i_core_clk);
                rd_chk("page", 4'h0, 8'h40);
            end
            @(posedge i_core_clk) i_fetch_addr <= rows[i].a;
            repeat (3) @(posedge i_core_clk);
            #1 chk("selects", {5'h00, b0, b1, m0}, {5'h00, rows[i].sel});
        end
        // Every area in turn; the write attempt meanwhile must be refused
        for (int k = 0; k < 4; k++) begin
            @(posedge i_core_clk) {i_prog_req, i_prog_area} <= {1'b1, 2'(k)};
        end
        @(posedge i_core_clk) i_switch <= 1'b0;
        repeat (2) @(posedge i_core_clk);
        #1 chk("area mask", {4'h0, mask}, 8'h0F);
        chk("selects off", {4'h0, b0, b1, m0, pact}, 8'h01);
        rd_chk("status", 4'h2, 8'h04);
        wr_reg(4'h1, 8'h02);
        @(posedge i_core_clk) i_prog_req <= 1'b0;
        repeat (3) @(posedge i_core_clk);
        wr_reg(4'h1, 8'h01);
        repeat (4) @(posedge i_core_clk);
        rd_chk("page kept", 4'h0, 8'h40);
        @(posedge i_core_clk) i_rst <= 1'b1;
        @(posedge i_core_clk) i_rst <= 1'b0;
        #1 chk("mask cleared", {4'h0, mask}, 8'h00);
        rd_chk("page after reset", 4'h0, 8'h00);
        results();
    end
endmodule
